// ---- hdl/smsi_top.sv ----
`timescale 1ns/1ps
`include "smsi_defines.svh"
module smsi_top
  import smsi_pkg::*;
#(
  parameter int TICK_CYC = `SMSI_TICK_CYC,
  parameter int LOCK_UNIT_CYC = `SMSI_TICK_CYC
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // non-volatile defaults, taken after reset release
  input  wire logic                     nvm_valid,
  input  wire logic                     nvm_amon_action,
  input  wire logic                     nvm_amon_hysteresis_enable,
  input  wire logic                     nvm_amon_enable,
  input  wire logic [`SMSI_LEVEL_W-1:0] nvm_amon_level,
  input  wire logic [`SMSI_TRIM_W-1:0]  factory_bandgap_trim,
  // analog supply monitor control write
  input  wire logic                     amon_wr,
  input  wire logic                     amon_rd,
  input  wire logic                     amon_enable_in,
  input  wire logic                     amon_mode_in,
  input  wire logic                     amon_action_in,
  input  wire logic                     amon_hysteresis_enable_in,
  input  wire logic                     amon_clk_en_in,
  input  wire logic [`SMSI_PSEL_W-1:0]  amon_psel_in,
  input  wire logic [`SMSI_LEVEL_W-1:0] amon_level_in,
  // core supply monitor control write
  input  wire logic                     cmon_wr,
  input  wire logic                     cmon_rd,
  input  wire logic                     cmon_enable_in,
  input  wire logic                     cmon_mode_in,
  input  wire logic                     cmon_action_in,
  input  wire logic                     cmon_hysteresis_enable_in,
  input  wire logic                     cmon_clk_en_in,
  input  wire logic [`SMSI_PSEL_W-1:0]  cmon_psel_in,
  input  wire logic [`SMSI_LEVEL_W-1:0] cmon_level_in,
  input  wire logic                     standby_sleep,
  // comparator results from the analog side
  input  wire logic                     analog_below,
  input  wire logic                     core_below,
  // bandgap
  input  wire logic                     bandgap_trim_wr,
  input  wire logic [`SMSI_TRIM_W-1:0]  bandgap_trim_in,
  // pll control and status
  input  wire logic                     pll_enable,
  input  wire logic                     pll_ratio_wr,
  input  wire logic                     pll_lock_raw,
  input  wire logic [`SMSI_LOCK_TIME_SETTING_W-1:0] lock_time_setting,
  input  wire logic                     filter_override,
  input  wire logic [`SMSI_FILT_W-1:0]  filter_sel_in,
  input  wire logic [`SMSI_FILT_W-1:0]  filter_auto,
  input  wire logic                     tdc_bypass_enable,
  // fll access
  input  wire logic                     fll_enable,
  input  wire logic                     fll_wr,
  input  wire logic                     fll_rd,
  input  wire logic                     sync_read_request,
  input  wire logic                     fll_sync_done,
  // oscillator and fll status bits
  input  wire logic [8:0]               osc_status,
  // interrupt registers
  input  wire logic                     irq_flag_wr,
  input  wire logic                     irq_enable_set_wr,
  input  wire logic                     irq_enable_clear_wr,
  input  wire logic [`SMSI_IRQ_W-1:0]   irq_wdata,
  // outputs
  output logic [`SMSI_IRQ_W-1:0]        power_clock_status,
  output logic [`SMSI_IRQ_W-1:0]        irq_flag_reg,
  output logic [`SMSI_IRQ_W-1:0]        irq_enable_reg,
  output logic                          irq,
  output logic                          wake_async,
  output logic                          bod_reset_req,
  output logic                          amon_comp_on,
  output logic                          amon_hysteresis_enable_out,
  output logic [`SMSI_LEVEL_W-1:0]      amon_level_out,
  output logic                          cmon_comp_on,
  output logic                          cmon_hysteresis_enable_out,
  output logic [`SMSI_LEVEL_W-1:0]      cmon_level_out,
  output logic [`SMSI_TRIM_W-1:0]       bandgap_trim,
  output logic [`SMSI_FILT_W-1:0]       pll_filter,
  output logic                          tdc_active,
  output logic                          fll_wr_accept,
  output logic                          bus_stall
);
  import smsi_pkg::*;

  if (TICK_CYC < 2 || LOCK_UNIT_CYC < 1) begin : g_bad_timing
    $error("smsi_top: bad timing parameter");
  end

  logic                     amon_en_q, amon_mode_q, amon_act_q, amon_hysteresis_enable_q, amon_cen_q;
  logic [`SMSI_PSEL_W-1:0]  amon_psel_q;
  logic [`SMSI_LEVEL_W-1:0] amon_level_q;
  logic                     cmon_en_q, cmon_mode_q, cmon_act_q, cmon_hysteresis_enable_q, cmon_cen_q;
  logic [`SMSI_PSEL_W-1:0]  cmon_psel_q;
  logic [`SMSI_LEVEL_W-1:0] cmon_level_q;
  logic                     amon_srdy, cmon_srdy, amon_busy, cmon_busy;
  logic                     amon_wr_ok, cmon_wr_ok;
  logic                     amon_det, cmon_det, amon_rdy, cmon_rdy;
  logic                     nvm_done_q, amon_rd_pend_q, cmon_rd_pend_q;
  logic [31:0]              tick_cnt_q;
  logic                     tick_1k;
  logic [`SMSI_TRIM_W-1:0]  trim_q;
  logic                     trim_loaded_q;
  logic                     lock_q, lock_prev_q, ratio_hold_q, lock_timer_timeout_q;
  logic [31:0]              lt_unit_q;
  logic [`SMSI_LOCK_TIME_SETTING_W+4:0] lt_cnt_q;
  logic                     pll_en_prev_q;
  logic [`SMSI_IRQ_W-1:0]   status, status_prev_q, flag_q, en_q, rise;
  logic                     fll_rd_pend_q;

  // writes while busy are held off by stall, never applied mid-sync
  assign amon_wr_ok = amon_wr && amon_srdy;
  assign cmon_wr_ok = cmon_wr && cmon_srdy;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) nvm_done_q <= 1'b0;
    else if (nvm_valid) nvm_done_q <= 1'b1;
  end

  // analog monitor config; user-row defaults arrive once after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amon_en_q    <= 1'b0;
      amon_mode_q  <= 1'b0;
      amon_act_q   <= 1'b0;
      amon_hysteresis_enable_q  <= 1'b0;
      amon_cen_q   <= 1'b0;
      amon_psel_q  <= '0;
      amon_level_q <= '0;
    end else if (nvm_valid && !nvm_done_q) begin
      amon_en_q    <= nvm_amon_enable;
      amon_act_q   <= nvm_amon_action;
      amon_hysteresis_enable_q  <= nvm_amon_hysteresis_enable;
      amon_level_q <= nvm_amon_level;
    end else if (amon_wr_ok) begin
      amon_en_q    <= amon_enable_in;
      amon_mode_q  <= amon_mode_in;
      amon_act_q   <= amon_action_in;
      amon_hysteresis_enable_q  <= amon_hysteresis_enable_in;
      amon_cen_q   <= amon_clk_en_in;
      amon_psel_q  <= amon_psel_in;
      amon_level_q <= amon_level_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmon_en_q    <= 1'b0;
      cmon_mode_q  <= 1'b0;
      cmon_act_q   <= 1'b0;
      cmon_hysteresis_enable_q  <= 1'b0;
      cmon_cen_q   <= 1'b0;
      cmon_psel_q  <= '0;
      cmon_level_q <= '0;
    end else if (cmon_wr_ok) begin
      cmon_en_q    <= cmon_enable_in;
      cmon_mode_q  <= cmon_mode_in;
      cmon_act_q   <= cmon_action_in;
      cmon_hysteresis_enable_q  <= cmon_hysteresis_enable_in;
      cmon_cen_q   <= cmon_clk_en_in;
      cmon_psel_q  <= cmon_psel_in;
      cmon_level_q <= cmon_level_in;
    end
  end

  assign amon_hysteresis_enable_out  = amon_hysteresis_enable_q;
  assign amon_level_out = amon_level_q;
  assign cmon_hysteresis_enable_out  = cmon_hysteresis_enable_q;
  assign cmon_level_out = cmon_level_q;

  smsi_sync_ctrl u_amon_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .start      (amon_wr_ok),
    .sync_ready (amon_srdy),
    .busy       (amon_busy)
  );
  smsi_sync_ctrl u_cmon_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .start      (cmon_wr_ok),
    .sync_ready (cmon_srdy),
    .busy       (cmon_busy)
  );

  // a read only stalls on the register that was just written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amon_rd_pend_q <= 1'b0;
      cmon_rd_pend_q <= 1'b0;
    end else begin
      if (amon_wr_ok) amon_rd_pend_q <= 1'b1;
      else if (!amon_busy) amon_rd_pend_q <= 1'b0;
      if (cmon_wr_ok) cmon_rd_pend_q <= 1'b1;
      else if (!cmon_busy) cmon_rd_pend_q <= 1'b0;
    end
  end

  // 1 kHz prescaler enable from the reference clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_q <= 32'h0000_0000;
    else if (tick_1k) tick_cnt_q <= 32'h0000_0000;
    else tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end
  assign tick_1k = (tick_cnt_q == 32'(TICK_CYC - 1));

  smsi_sampler u_amon (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .enable     (amon_en_q),
    .mode       (amon_mode_q),
    .clk_en     (amon_cen_q),
    .psel       (amon_psel_q),
    .cont_block (1'b0),
    .tick_1k    (tick_1k),
    .below      (analog_below),
    .comp_on    (amon_comp_on),
    .detect     (amon_det),
    .ready      (amon_rdy)
  );
  smsi_sampler u_cmon (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .enable     (cmon_en_q),
    .mode       (cmon_mode_q),
    .clk_en     (cmon_cen_q),
    .psel       (cmon_psel_q),
    .cont_block (standby_sleep),
    .tick_1k    (tick_1k),
    .below      (core_below),
    .comp_on    (cmon_comp_on),
    .detect     (cmon_det),
    .ready      (cmon_rdy)
  );

  // action bit picks reset or interrupt
  assign bod_reset_req = (amon_det && amon_act_q) || (cmon_det && cmon_act_q);
  // raw detect level, usable with no bus clock running
  assign wake_async    = analog_below && amon_en_q && !amon_act_q;

  // bandgap trim taken from factory data after reset, then writable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q        <= '0;
      trim_loaded_q <= 1'b0;
    end else if (!trim_loaded_q) begin
      trim_q        <= factory_bandgap_trim;
      trim_loaded_q <= 1'b1;
    end else if (bandgap_trim_wr) trim_q <= bandgap_trim_in;
  end
  assign bandgap_trim = trim_q;

  // filter auto unless overridden, tdc bypass
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pll_filter <= '0;
    else pll_filter <= filter_override ? filter_sel_in : filter_auto;
  end
  assign tdc_active = !tdc_bypass_enable;

  // lock status drops on a ratio update while running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ratio_hold_q <= 1'b0;
    else if (pll_ratio_wr && pll_enable) ratio_hold_q <= 1'b1;
    else if (!pll_lock_raw) ratio_hold_q <= 1'b0;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) lock_q <= 1'b0;
    else lock_q <= pll_enable && pll_lock_raw && !ratio_hold_q && !(pll_ratio_wr && pll_enable);
  end

  // lock timer: setting counts 32-unit steps from pll start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_en_prev_q <= 1'b0;
      lt_unit_q     <= 32'h0000_0000;
      lt_cnt_q      <= '0;
      lock_timer_timeout_q        <= 1'b0;
    end else begin
      pll_en_prev_q <= pll_enable;
      if (!pll_enable || lock_time_setting == '0 || (pll_enable && !pll_en_prev_q)) begin
        lt_unit_q <= 32'h0000_0000;
        lt_cnt_q  <= '0;
        lock_timer_timeout_q    <= 1'b0;
      end else if (!lock_timer_timeout_q) begin
        if (lt_unit_q == 32'(LOCK_UNIT_CYC - 1)) begin
          lt_unit_q <= 32'h0000_0000;
          lt_cnt_q  <= lt_cnt_q + 1'b1;
          if (lt_cnt_q + 1'b1 >= {lock_time_setting, 5'h00}) lock_timer_timeout_q <= 1'b1;
        end else lt_unit_q <= lt_unit_q + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    status = '0;
    status[8:0]                = osc_status;
    status[`SMSI_B_AMON_RDY]   = amon_rdy;
    status[`SMSI_B_AMON_DET]   = amon_det;
    status[`SMSI_B_AMON_SRDY]  = amon_srdy;
    status[`SMSI_B_CMON_RDY]   = cmon_rdy;
    status[`SMSI_B_CMON_DET]   = cmon_det;
    status[`SMSI_B_CMON_SRDY]  = cmon_srdy;
    status[`SMSI_B_PLL_LOCK]   = lock_q;
    status[`SMSI_B_PLL_LOST]   = !lock_q && lock_prev_q;
    status[`SMSI_B_PLL_LOCK_TIMER_TIMEOUT]   = lock_timer_timeout_q;
    status[`SMSI_B_PLL_FAIL]   = !lock_q && lock_prev_q;
  end
  assign power_clock_status = status;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // sync-ready idles high; a zero here would fake a rising edge after reset
      status_prev_q <= (19'h0_0001 << `SMSI_B_AMON_SRDY) | (19'h0_0001 << `SMSI_B_CMON_SRDY);
      lock_prev_q   <= 1'b0;
    end else begin
      status_prev_q <= status;
      lock_prev_q   <= lock_q;
    end
  end

  // edge detect; lost/fail bits are already falling-edge pulses
  always_comb begin
    rise = status & ~status_prev_q;
    rise[`SMSI_B_PLL_LOST] = status[`SMSI_B_PLL_LOST];
    rise[`SMSI_B_PLL_FAIL] = status[`SMSI_B_PLL_FAIL];
  end

  // set beats write-one clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) flag_q <= '0;
    else flag_q <= rise | (flag_q & ~(irq_flag_wr ? irq_wdata : '0));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) en_q <= '0;
    else if (irq_enable_set_wr) en_q <= en_q | irq_wdata;
    else if (irq_enable_clear_wr) en_q <= en_q & ~irq_wdata;
  end

  assign irq_flag_reg   = flag_q;
  assign irq_enable_reg = en_q;
  assign irq            = |(flag_q & en_q);

  // fll writes dropped while not ready
  assign fll_wr_accept = fll_wr && osc_status[`SMSI_B_FLL_READY];

  // read without prior request stalls until sync, not when disabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) fll_rd_pend_q <= 1'b0;
    else if (sync_read_request || (fll_rd && fll_enable && !fll_sync_done)) fll_rd_pend_q <= 1'b1;
    else if (fll_sync_done) fll_rd_pend_q <= 1'b0;
  end

  assign bus_stall = (amon_wr && amon_busy) || (cmon_wr && cmon_busy) ||
                     (amon_rd && amon_rd_pend_q) || (cmon_rd && cmon_rd_pend_q) ||
                     (fll_rd && fll_enable && !fll_sync_done &&
                      (fll_rd_pend_q || !sync_read_request));
endmodule

// ---- shared/smsi_defines.svh ----
`ifndef SMSI_DEFINES_SVH
`define SMSI_DEFINES_SVH
// Summary of operation
// - set pll lock-fail flag on falling lock edge; clear only by writing one.
// - filter auto unless override field given; tdc bypassed when low-power enable set.
// - analog supply below level raises interrupt or reset per action; status readable.
// - analog monitor config loaded from user row at start-up; software writes override.
// - enabled monitor with mode zero monitors its rail continuously.
// - core monitor gets no continuous monitoring in standby sleep.
// - both monitors reset to continuous mode.
// - sampling mode enables monitor briefly each tick, then disables it.
// - sampling tick is 1 kHz prescaler clock divided by 2^(psel+1).
// - hysteresis bit adds hysteresis to threshold in both modes.
// - bandgap trim loaded from factory data at reset; writes replace it.
// - each status bit rising edge sets its interrupt flag.
// - analog detect interrupt also wakes system without a bus clock.
// - lock timer timeout flag set once programmed lock time elapsed.
// - pll lock flag set when lock status asserts.
// - enable-set ones enable, enable-clear ones disable, zeros do nothing.
// - request active while a flag and its enable are both set.
// - all requests ORed onto one line.
// - fll control writes discarded while fll ready is zero.
// - fll read without request syncs and stalls unless disabled; request starts early.
// - monitor write clears sync-ready until synced; access meanwhile stalls.
// - ratio update while enabled clears lock, set again when stable.
`define SMSI_IRQ_W          19
`define SMSI_B_CRYSTAL_OSC_READY      0
`define SMSI_B_FLL_READY      4
`define SMSI_B_FLL_FINE_LOCKED    6
`define SMSI_B_AMON_RDY     9
`define SMSI_B_AMON_DET     10
`define SMSI_B_AMON_SRDY    11
`define SMSI_B_CMON_RDY     12
`define SMSI_B_CMON_DET     13
`define SMSI_B_CMON_SRDY    14
`define SMSI_B_PLL_LOCK     15
`define SMSI_B_PLL_LOST     16
`define SMSI_B_PLL_LOCK_TIMER_TIMEOUT     17
`define SMSI_B_PLL_FAIL     18
`define SMSI_REF_HZ         50000000
`define SMSI_TICK_HZ        1000
`define SMSI_TICK_CYC       (`SMSI_REF_HZ / `SMSI_TICK_HZ)
`define SMSI_SYNC_CYC       3
`define SMSI_PSEL_W         4
`define SMSI_LEVEL_W        6
`define SMSI_TRIM_W         7
`define SMSI_LOCK_TIME_SETTING_W        3
`define SMSI_FILT_W         2
`endif

// ---- shared/smsi_pkg.sv ----
package smsi_pkg;
  typedef enum logic [1:0] {
    SMSI_SYNC_IDLE = 2'b00,
    SMSI_SYNC_BUSY = 2'b01,
    SMSI_SYNC_DONE = 2'b10
  } smsi_sync_t;
  typedef enum logic [1:0] {
    SMSI_SMP_IDLE = 2'b00,
    SMSI_SMP_ON   = 2'b01,
    SMSI_SMP_EVAL = 2'b10
  } smsi_smp_t;
endpackage

// ---- hdl/smsi_sync_ctrl.sv ----
`timescale 1ns/1ps
`include "smsi_defines.svh"
// write-synchronisation tracker for one monitor control register
module smsi_sync_ctrl
  import smsi_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // request
  input  wire logic start,
  // status
  output logic      sync_ready,
  output logic      busy
);
  import smsi_pkg::*;
  smsi_sync_t state_q;
  logic [1:0] cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SMSI_SYNC_IDLE;
      cnt_q   <= 2'h0;
    end else begin
      unique case (state_q)
        // a write taken as ready returns must start a fresh sync
        SMSI_SYNC_IDLE, SMSI_SYNC_DONE: begin
          if (start) begin
            state_q <= SMSI_SYNC_BUSY;
            cnt_q   <= 2'(`SMSI_SYNC_CYC - 1);
          end else state_q <= SMSI_SYNC_IDLE;
        end
        SMSI_SYNC_BUSY: begin
          if (cnt_q == 2'h0) state_q <= SMSI_SYNC_DONE;
          else cnt_q <= cnt_q - 2'h1;
        end
        default:        state_q <= SMSI_SYNC_IDLE;
      endcase
    end
  end

  // ready clears during sync and returns at completion
  assign busy       = (state_q == SMSI_SYNC_BUSY);
  assign sync_ready = !busy;
endmodule

// ---- hdl/smsi_sampler.sv ----
`timescale 1ns/1ps
`include "smsi_defines.svh"
// one supply monitor: mode, sampling tick and detect evaluation
module smsi_sampler
  import smsi_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // configuration
  input  wire logic                    enable,
  input  wire logic                    mode,
  input  wire logic                    clk_en,
  input  wire logic [`SMSI_PSEL_W-1:0] psel,
  input  wire logic                    cont_block,
  // prescaler tick and comparator
  input  wire logic                    tick_1k,
  input  wire logic                    below,
  // outputs
  output logic                         comp_on,
  output logic                         detect,
  output logic                         ready
);
  import smsi_pkg::*;
  smsi_smp_t state_q;
  logic [15:0] div_q;
  logic        smp_tick;
  logic [15:0] div_max;

  // 2^(psel+1) prescaler ticks per sample
  assign div_max  = 16'((32'h0000_0002 << psel) - 32'h0000_0001);
  assign smp_tick = tick_1k && (div_q == div_max);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) div_q <= 16'h0000;
    else if (!clk_en || !mode) div_q <= 16'h0000;
    else if (tick_1k) div_q <= smp_tick ? 16'h0000 : div_q + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) state_q <= SMSI_SMP_IDLE;
    else begin
      unique case (state_q)
        SMSI_SMP_IDLE: if (enable && mode && clk_en && smp_tick) state_q <= SMSI_SMP_ON;
        SMSI_SMP_ON:   state_q <= SMSI_SMP_EVAL;
        SMSI_SMP_EVAL: state_q <= SMSI_SMP_IDLE;
        default:       state_q <= SMSI_SMP_IDLE;
      endcase
    end
  end

  // continuous when enabled with mode zero and cont_block low
  assign comp_on = enable && ((!mode && !cont_block) || (mode && state_q != SMSI_SMP_IDLE));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) detect <= 1'b0;
    else if (!enable) detect <= 1'b0;
    else if (!mode && !cont_block) detect <= below;
    else if (mode && state_q == SMSI_SMP_EVAL) detect <= below; // held between samples
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ready <= 1'b0;
    else ready <= enable;
  end
endmodule

// ---- sim/smsi_monitor.sv ----
`timescale 1ns/1ps
`include "smsi_defines.svh"
module smsi_monitor (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  // strobes and data
  input wire logic                   irq_flag_wr,
  input wire logic                   irq_enable_set_wr,
  input wire logic                   irq_enable_clear_wr,
  input wire logic [`SMSI_IRQ_W-1:0] irq_wdata,
  input wire logic                   fll_wr,
  input wire logic                   amon_wr,
  input wire logic                   bandgap_trim_wr,
  input wire logic [`SMSI_TRIM_W-1:0] bandgap_trim_in,
  input wire logic                   pll_enable,
  input wire logic                   pll_lock_raw,
  input wire logic [8:0]             osc_status,
  // results
  input wire logic [`SMSI_IRQ_W-1:0] power_clock_status,
  input wire logic [`SMSI_IRQ_W-1:0] irq_flag_reg,
  input wire logic [`SMSI_IRQ_W-1:0] irq_enable_reg,
  input wire logic                   irq,
  input wire logic                   fll_wr_accept,
  input wire logic                   bus_stall,
  input wire logic [`SMSI_TRIM_W-1:0] bandgap_trim
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  irq_merge_a: assert property (irq == |(irq_flag_reg & irq_enable_reg))
    else $error("irq line differs from flag and enable");
  en_set_a: assert property (irq_enable_set_wr |=> (irq_enable_reg & $past(irq_wdata)) == $past(irq_wdata))
    else $error("enable set not applied");
  en_clear_a: assert property (irq_enable_clear_wr && !irq_enable_set_wr |=> (irq_enable_reg & $past(irq_wdata)) == '0)
    else $error("enable clear not applied");
  // a flag may only drop where a one was written to it
  flag_keep_a: assert property (1'b1 |=> ($past(irq_flag_reg) & ~irq_flag_reg
    & ~($past(irq_wdata) & {`SMSI_IRQ_W{$past(irq_flag_wr)}})) == '0)
    else $error("flag dropped without write one");
  fll_gate_a: assert property (fll_wr_accept |-> fll_wr && osc_status[4])
    else $error("fll write accepted while not ready");
  sync_busy_a: assert property (amon_wr && power_clock_status[11] |=>
    !power_clock_status[11] [*3] ##1 power_clock_status[11])
    else $error("sync ready sequence wrong");
  sync_stall_a: assert property (amon_wr && !power_clock_status[11] |-> bus_stall)
    else $error("no stall on write during sync");
  trim_write_a: assert property (bandgap_trim_wr |=> bandgap_trim == $past(bandgap_trim_in))
    else $error("trim write not applied");
  osc_rise_a: assert property ($rose(osc_status[0]) |-> ##[1:2] irq_flag_reg[0])
    else $error("ready rise did not set flag");
  lock_fail_a: assert property (pll_enable && $fell(pll_lock_raw) |-> ##[1:3] irq_flag_reg[18])
    else $error("lock fall did not set fail flag");
endmodule
bind smsi_top smsi_monitor i_smsi_monitor (.*);

// ---- sim/smsi_top_tb.sv ----
`timescale 1ns/1ps
`include "smsi_defines.svh"
module smsi_top_tb;
  import smsi_pkg::*;
  logic ref_clk = 0, rst_n = 0;
  logic nvm_valid = 1, nvm_amon_action = 0, nvm_amon_hysteresis_enable = 1, nvm_amon_enable = 1;
  logic amon_wr = 0, amon_rd = 0, amon_enable_in = 1, amon_mode_in = 0, amon_action_in = 0;
  logic amon_hysteresis_enable_in = 0, amon_clk_en_in = 0, cmon_wr = 0, cmon_rd = 0, cmon_enable_in = 0;
  logic cmon_mode_in = 0, cmon_action_in = 0, cmon_hysteresis_enable_in = 0, cmon_clk_en_in = 0;
  logic standby_sleep = 0, analog_below = 0, core_below = 0, bandgap_trim_wr = 0;
  logic pll_enable = 0, pll_ratio_wr = 0, pll_lock_raw = 0, filter_override = 0, tdc_bypass_enable = 0;
  logic fll_enable = 0, fll_wr = 0, fll_rd = 0, sync_read_request = 0, fll_sync_done = 0;
  logic irq_flag_wr = 0, irq_enable_set_wr = 0, irq_enable_clear_wr = 0;
  logic [`SMSI_LEVEL_W-1:0] nvm_amon_level = 6'h0c, amon_level_in = 6'h00, cmon_level_in = 6'h00;
  logic [`SMSI_TRIM_W-1:0] factory_bandgap_trim = 7'h5a, bandgap_trim_in = 7'h00;
  logic [`SMSI_PSEL_W-1:0] amon_psel_in = 4'h0, cmon_psel_in = 4'h0;
  logic [`SMSI_LOCK_TIME_SETTING_W-1:0] lock_time_setting = 3'h1;
  logic [`SMSI_FILT_W-1:0] filter_sel_in = 2'h0, filter_auto = 2'h0, pll_filter;
  logic [8:0] osc_status = 9'h000;
  logic [`SMSI_IRQ_W-1:0] irq_wdata = '0, power_clock_status, irq_flag_reg, irq_enable_reg;
  logic irq, wake_async, bod_reset_req, amon_comp_on, amon_hysteresis_enable_out, cmon_comp_on, cmon_hysteresis_enable_out;
  logic tdc_active, fll_wr_accept, bus_stall;
  logic [`SMSI_LEVEL_W-1:0] amon_level_out, cmon_level_out;
  logic [`SMSI_TRIM_W-1:0] bandgap_trim;
  int num_errors = 0, cmp_count = 0, cyc_cnt = 0;

  smsi_top #(.TICK_CYC(20), .LOCK_UNIT_CYC(1)) i_smsi_top (.*);

  always #10 ref_clk = ~ref_clk;
  // hang guard, well above the roughly 100 cycles the run needs
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // k selects: 0 fll, 1 trim, 2 monitor, 3 enable clear, 4 enable set, 5 flag
  task automatic strobe(input int k);
    @(posedge ref_clk) {irq_flag_wr, irq_enable_set_wr, irq_enable_clear_wr, amon_wr, bandgap_trim_wr, fll_wr} <= 6'h01 << k;
    @(posedge ref_clk) {irq_flag_wr, irq_enable_set_wr, irq_enable_clear_wr, amon_wr, bandgap_trim_wr, fll_wr} <= 6'h00;
    #1;
  endtask
  task automatic t_reset;
    cyc(3);
    chk(amon_level_out, 6'h0c);
    chk(amon_hysteresis_enable_out, 1'b1);
    chk(bandgap_trim, 7'h5a);
    chk(power_clock_status[11], 1'b1);
    chk(irq_flag_reg[11], 1'b0);
  endtask
  task automatic t_mon;
    @(posedge ref_clk) begin
      analog_below <= 1'b1;
      filter_override <= 1'b1;
      filter_sel_in <= 2'h2;
      tdc_bypass_enable <= 1'b1;
    end
    cyc(2);
    chk(amon_comp_on, 1'b1);
    chk(wake_async, 1'b1);
    chk(power_clock_status[10], 1'b1);
    chk(bod_reset_req, 1'b0);
    chk(pll_filter, 2'h2);
    chk(tdc_active, 1'b0);
  endtask
  task automatic t_irq;
    @(posedge ref_clk) osc_status <= 9'h001;
    cyc(3);
    chk(irq_flag_reg[0], 1'b1);
    chk(irq, 1'b0);
    irq_wdata <= 19'h0_0001;
    strobe(4);
    chk(irq, 1'b1);
    irq_wdata <= 19'h0_0000;
    strobe(5);
    strobe(3);
    chk(irq_flag_reg[0], 1'b1);
    chk(irq_enable_reg[0], 1'b1);
    irq_wdata <= 19'h0_0001;
    strobe(3);
    chk(irq, 1'b0);
    strobe(4);
    strobe(5);
    chk(irq_flag_reg[0], 1'b0);
    chk(irq, 1'b0);
  endtask
  task automatic t_sync;
    amon_level_in <= 6'h2a;
    amon_hysteresis_enable_in <= 1'b0;
    strobe(2);
    chk(power_clock_status[11], 1'b0);
    @(posedge ref_clk) begin
      amon_level_in <= 6'h15;
      amon_wr <= 1'b1;
    end
    #1;
    chk(bus_stall, 1'b1);
    chk(amon_level_out, 6'h2a);
    // stalled write is held, then lands once sync-ready returns
    while (bus_stall) cyc(1);
    @(posedge ref_clk) amon_wr <= 1'b0;
    cyc(6);
    chk(power_clock_status[11], 1'b1);
    chk(irq_flag_reg[11], 1'b1);
    chk(amon_level_out, 6'h15);
    chk(amon_hysteresis_enable_out, 1'b0);
  endtask
  task automatic t_misc;
    bandgap_trim_in <= 7'h33;
    strobe(1);
    chk(bandgap_trim, 7'h33);
    @(posedge ref_clk) fll_wr <= 1'b1;
    #1;
    chk(fll_wr_accept, 1'b0);
    @(posedge ref_clk) osc_status[4] <= 1'b1;
    #1;
    chk(fll_wr_accept, 1'b1);
    @(posedge ref_clk) fll_wr <= 1'b0;
  endtask
  task automatic t_pll;
    @(posedge ref_clk) begin
      pll_enable <= 1'b1;
      pll_lock_raw <= 1'b1;
    end
    cyc(3);
    chk(irq_flag_reg[15], 1'b1);
    @(posedge ref_clk) pll_lock_raw <= 1'b0;
    cyc(4);
    chk(irq_flag_reg[18], 1'b1);
    chk(irq_flag_reg[16], 1'b1);
    cyc(40);
    chk(irq_flag_reg[17], 1'b1);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_irq();
    t_sync();
    t_mon();
    t_misc();
    t_pll();
    end_of_test();
  end
endmodule
